// File: src/smsc_top.sv
// Purpose: digital control of supplies, power-fail warning, bus
//          detection and deep sleep entry and wake
// Assumes: analog comparator inputs are asynchronous and synchronised
// Notes:   registers on a plain strobe port, read data one cycle later
`timescale 1ns/1ps

module smsc_top
    import smsc_pkg::*;
#(
    parameter int USB_SET_CYC = SMSC_USB_SET_CYC  // settle count
) (
    input  wire logic        ref_clk_i,     // system clock
    input  wire logic        rst_i,         // power-on reset, sync high
    input  wire logic        brownout_i,    // brownout comparator, async
    input  wire logic        core_pwr_i,    // core pin powered, async
    input  wire logic        high_pwr_i,    // high supply pin powered
    input  wire logic        below_thr_i,   // supply under threshold
    input  wire logic        vbus_i,        // bus voltage valid, async
    input  wire logic        port_sense_i,  // gpio detect, async
    input  wire logic        high_freq_clock_run_i,   // high freq clock running
    input  wire logic        debug_mode_i,  // debug interface active
    input  wire logic [11:0] addr_i,        // register address
    input  wire logic [31:0] wdata_i,       // write data
    input  wire logic        wr_i,          // write strobe
    input  wire logic        rd_i,          // read strobe
    output logic      [31:0] rdata_o,       // read data
    output logic             first_en_o,    // first stage enable
    output logic             linear_en_o,   // second stage linear
    output logic             switcher_o,    // second stage switcher
    output logic             pof_on_o,      // comparator powered
    output logic [3:0]       pof_thr_o,     // comparator threshold
    output logic             flash_blk_o,   // flash write inhibit
    output logic             usb_reg_o,     // usb regulator on
    output logic             sys_rst_o,     // system reset request
    output logic             core_off_o,    // core powered down
    output logic [3:0]       ram_ret_o,     // ram retention per section
    output logic             irq_o          // event interrupt
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0]  s_brn, s_core, s_high, s_blw, s_vb, s_ps;  // syncs
        logic        vb_q;          // bus level last cycle
        logic        pof_act_q;     // comparator active last cycle
        logic [3:0]  thr_q;         // threshold last cycle
        logic        blw_q;         // below last cycle
        logic        pof_en;        // comparator enable
        logic [3:0]  thr;           // threshold code
        logic        sw_en;         // switcher enable
        logic        usb_en;        // usb function enabled
        logic [3:0]  ram;           // ram retention bits
        logic [3:0]  evt;           // sticky events
        logic [3:0]  inten;         // interrupt enables
        logic [31:0] cause;         // reset cause record
        logic        rdy;           // usb regulator ready
        logic [31:0] cnt;           // settling counter
        smsc_pwr_t   pwr;           // power state
        logic [31:0] rdata;         // read data register
    } smsc_st_t;

    smsc_st_t st;         // registered state
    smsc_st_t next_st;    // next state

    // flag index
    localparam int E_POF = 0;   // warning
    localparam int E_DET = 1;   // bus detected
    localparam int E_REM = 2;   // bus removed
    localparam int E_RDY = 3;   // usb ready

    // synchronised levels, read only from the second stage
    logic brn, core_p, high_p, blw, vb, ps;  // clean inputs
    assign brn    = st.s_brn[1];
    assign core_p = st.s_core[1];
    assign high_p = st.s_high[1];
    assign blw    = st.s_blw[1];
    assign vb     = st.s_vb[1];
    assign ps     = st.s_ps[1];

    logic        pof_act;   // comparator allowed to run
    logic        sleeping;  // real or emulated sleep
    logic [3:0]  ev_set;    // event pulses
    logic [3:0]  ev_clr;    // software clears

    // ------------------------------------------------------------------
    // next state logic
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;
        // two-flop synchronisers
        next_st.s_brn  = {st.s_brn[0],  brownout_i};
        next_st.s_core = {st.s_core[0], core_pwr_i};
        next_st.s_high = {st.s_high[0], high_pwr_i};
        next_st.s_blw  = {st.s_blw[0],  below_thr_i};
        next_st.s_vb   = {st.s_vb[0],   vbus_i};
        next_st.s_ps   = {st.s_ps[0],   port_sense_i};

        sleeping = (st.pwr == SMSC_SLEEP) || (st.pwr == SMSC_EMUL);
        // no compare while asleep or with the fast clock stopped
        pof_act  = st.pof_en && high_freq_clock_run_i && !sleeping;
        next_st.pof_act_q = pof_act;
        next_st.thr_q     = st.thr;
        next_st.blw_q     = blw;
        next_st.vb_q      = vb;

        // warning: falling edge, enable while low, threshold change while low
        ev_set = '0;
        ev_set[E_POF] = pof_act && blw &&
                        (!st.blw_q || !st.pof_act_q ||
                         st.thr != st.thr_q);
        ev_set[E_DET] = vb && !st.vb_q;
        ev_set[E_REM] = !vb && st.vb_q;

        // usb regulator settling
        if (st.usb_en && vb) begin
            if (!st.rdy) begin
                if (st.cnt >= 32'(USB_SET_CYC - 1)) begin
                    next_st.rdy   = 1'b1;
                    ev_set[E_RDY] = 1'b1;
                end else begin
                    next_st.cnt = st.cnt + 32'h1;
                end
            end
        end else begin
            next_st.rdy = 1'b0;
            next_st.cnt = '0;
        end

        // register writes
        ev_clr = '0;
        if (wr_i) begin
            case (addr_i)
                SMSC_EVT_POWER_FAIL_WARNING_EVENT_OFS: ev_clr[E_POF] = !wdata_i[0];
                SMSC_EVT_BUSDET_OFS:  ev_clr[E_DET] = !wdata_i[0];
                SMSC_EVT_BUSREM_OFS:  ev_clr[E_REM] = !wdata_i[0];
                SMSC_EVT_USBRDY_OFS:  ev_clr[E_RDY] = !wdata_i[0];
                SMSC_INTEN_OFS: next_st.inten = wdata_i[3:0];
                SMSC_CAUSE_OFS: next_st.cause = st.cause & ~wdata_i;
                SMSC_POFCFG_OFS: begin
                    next_st.pof_en = wdata_i[SMSC_POF_EN_BIT];
                    next_st.thr    = wdata_i[SMSC_POF_THR_LSB +: SMSC_THR_W];
                end
                SMSC_SWEN_OFS:   next_st.sw_en  = wdata_i[0];
                SMSC_USBEN_OFS:  next_st.usb_en = wdata_i[0];
                SMSC_RAMPWR_OFS: next_st.ram    = wdata_i[3:0];
                default: ;
            endcase
        end
        // set wins over clear
        next_st.evt = (st.evt & ~ev_clr) | ev_set;

        // power state
        case (st.pwr)
            SMSC_RUN: begin
                if (wr_i && addr_i == SMSC_SLEEP_OFS && wdata_i[0]) begin
                    // debug keeps the core and regulators up; the comparator still stops
                    next_st.pwr = debug_mode_i ? SMSC_EMUL : SMSC_SLEEP;
                end
            end
            SMSC_SLEEP, SMSC_EMUL: begin
                if (vb && !st.vb_q) begin
                    next_st.cause[SMSC_CAUSE_BUS] = 1'b1;
                    next_st.pwr = SMSC_WAKE;
                end else if (ps) begin
                    next_st.cause[SMSC_CAUSE_DET] = 1'b1;
                    next_st.pwr = SMSC_WAKE;
                end
            end
            SMSC_WAKE: next_st.pwr = SMSC_RUN;
            default:   next_st.pwr = SMSC_RUN;
        endcase

        // registered read data
        next_st.rdata = '0;
        if (rd_i) begin
            case (addr_i)
                SMSC_EVT_POWER_FAIL_WARNING_EVENT_OFS: next_st.rdata[0]   = st.evt[E_POF];
                SMSC_EVT_BUSDET_OFS:  next_st.rdata[0]   = st.evt[E_DET];
                SMSC_EVT_BUSREM_OFS:  next_st.rdata[0]   = st.evt[E_REM];
                SMSC_EVT_USBRDY_OFS:  next_st.rdata[0]   = st.evt[E_RDY];
                SMSC_INTEN_OFS:       next_st.rdata[3:0] = st.inten;
                SMSC_CAUSE_OFS:       next_st.rdata      = st.cause;
                SMSC_USBSTAT_OFS:     next_st.rdata[1:0] = {st.rdy, vb};
                SMSC_POFCFG_OFS: begin
                    next_st.rdata[SMSC_POF_EN_BIT] = st.pof_en;
                    next_st.rdata[SMSC_POF_THR_LSB +: SMSC_THR_W] = st.thr;
                end
                SMSC_SWEN_OFS:   next_st.rdata[0] = st.sw_en;
                SMSC_USBEN_OFS:  next_st.rdata[0] = st.usb_en;
                // 1 = high voltage mode: only the high pin powered
                SMSC_MODE_OFS:   next_st.rdata[0] = high_p && !core_p;
                SMSC_RAMPWR_OFS: next_st.rdata[3:0] = st.ram;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // registers; ram bits and cause survive the wake reset
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            st       <= '0;
            st.ram   <= SMSC_RAM_RST;
            st.cause <= SMSC_CAUSE_RST;
            st.pwr   <= SMSC_RUN;
        end else if (st.pwr == SMSC_WAKE) begin
            // wake reset clears control but keeps retained state
            st        <= '0;
            st.s_brn  <= next_st.s_brn;
            st.s_core <= next_st.s_core;
            st.s_high <= next_st.s_high;
            st.s_blw  <= next_st.s_blw;
            st.s_vb   <= next_st.s_vb;
            st.s_ps   <= next_st.s_ps;
            st.vb_q   <= next_st.vb_q;
            st.ram    <= st.ram;
            st.cause  <= st.cause;
            st.pwr    <= SMSC_RUN;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign rdata_o     = st.rdata;
    assign first_en_o  = !core_p && !(st.pwr == SMSC_SLEEP);
    assign switcher_o  = st.sw_en && st.pwr != SMSC_SLEEP;
    assign linear_en_o = !st.sw_en && st.pwr != SMSC_SLEEP;
    assign pof_on_o    = pof_act;
    assign pof_thr_o   = st.thr;
    assign flash_blk_o = pof_act && blw;
    assign usb_reg_o   = st.usb_en && vb;
    assign sys_rst_o   = rst_i || brn || st.pwr == SMSC_WAKE;
    assign core_off_o  = st.pwr == SMSC_SLEEP;
    assign ram_ret_o   = st.ram;
    assign irq_o       = |(st.evt & st.inten);

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    // all checks run on the one system clock and rest during reset; the
    // synchronised levels are used so that pin noise cannot trip them

    // a stage never runs both regulator types at once
    a_stage_excl: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !(switcher_o && linear_en_o)) else $error("both regulators on");

    // with the core pin powered the first stage must stay off
    a_first_off: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        core_p |-> !first_en_o) else $error("first stage on");

    // the flash inhibit only comes from a live comparator
    a_flash_blk: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        flash_blk_o |-> st.pof_en && high_freq_clock_run_i)
        else $error("flash block without comparator");

    // real or emulated sleep keeps the comparator quiet
    a_pof_sleep: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        sleeping |-> !pof_on_o) else $error("comparator on in sleep");

    // a fresh fall below the threshold always leaves a flag behind
    a_pof_event: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (pof_act && blw && !st.blw_q) |=> st.evt[E_POF])
        else $error("warning not raised");

    // bus edges land in their sticky flags one cycle later
    a_bus_det: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $rose(vb) |=> st.evt[E_DET]) else $error("detect lost");
    a_bus_rem: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $fell(vb) |=> st.evt[E_REM]) else $error("remove lost");

    // ready may only rise once the settling count has run out
    a_usb_settle: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        $rose(st.rdy) |-> st.cnt == 32'(USB_SET_CYC - 1))
        else $error("ready before settling");

    // a sleep command without debug powers the core down next cycle
    a_sleep_entry: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (st.pwr == SMSC_RUN && wr_i && addr_i == SMSC_SLEEP_OFS &&
         wdata_i[0] && !debug_mode_i) |=> core_off_o)
        else $error("sleep not entered");

    // without a wake source the device stays asleep
    a_wake_only: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (st.pwr == SMSC_SLEEP && !ps && !(vb && !st.vb_q)) |=>
        st.pwr == SMSC_SLEEP) else $error("false wake");

    // every way out of sleep passes through the reset pulse
    a_wake_rst: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (st.pwr == SMSC_WAKE) |-> sys_rst_o ##1 st.pwr == SMSC_RUN)
        else $error("wake without reset");

    // a bus wake is recorded in the cause word across the wake reset
    a_bus_cause: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (st.pwr == SMSC_SLEEP && vb && !st.vb_q) |=> ##1
        st.cause[SMSC_CAUSE_BUS]) else $error("cause bit missing");

    // retention bits must not move while the core is down
    a_ram_keep: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (st.pwr == SMSC_SLEEP) |=> $stable(ram_ret_o))
        else $error("retention lost");

    // emulated sleep keeps the core and a regulator running
    a_emul_power: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (st.pwr == SMSC_EMUL) |-> !core_off_o && (linear_en_o || switcher_o))
        else $error("emulation cut power");

    // a flag raised in the same cycle as its clear must survive
    a_set_wins: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (ev_set[E_DET] && ev_clr[E_DET]) |=> st.evt[E_DET])
        else $error("clear beat set");

endmodule

// File: inc/smsc_pkg.sv
// Purpose: shared constants and types for the supply monitor block
// Assumes: 40 MHz reference clock, plain register port
// Notes:   register word offsets are byte addresses on a 12-bit port
package smsc_pkg;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [11:0] SMSC_EVT_POWER_FAIL_WARNING_EVENT_OFS = 12'h108; // warning flag
    localparam logic [11:0] SMSC_EVT_BUSDET_OFS  = 12'h11c; // bus detected
    localparam logic [11:0] SMSC_EVT_BUSREM_OFS  = 12'h120; // bus removed
    localparam logic [11:0] SMSC_EVT_USBRDY_OFS  = 12'h124; // usb ready
    localparam logic [11:0] SMSC_INTEN_OFS       = 12'h304; // irq enables
    localparam logic [11:0] SMSC_CAUSE_OFS       = 12'h400; // reset cause
    localparam logic [11:0] SMSC_USBSTAT_OFS     = 12'h438; // usb status
    localparam logic [11:0] SMSC_SLEEP_OFS       = 12'h500; // deep sleep
    localparam logic [11:0] SMSC_POFCFG_OFS      = 12'h510; // pof config
    localparam logic [11:0] SMSC_SWEN_OFS        = 12'h578; // switcher en
    localparam logic [11:0] SMSC_MODE_OFS        = 12'h640; // supply mode
    localparam logic [11:0] SMSC_USBEN_OFS       = 12'h700; // usb enable
    localparam logic [11:0] SMSC_RAMPWR_OFS      = 12'h900; // ram power

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int          SMSC_POF_EN_BIT   = 0;       // pof enable
    localparam int          SMSC_POF_THR_LSB  = 1;       // threshold lsb
    localparam int          SMSC_THR_W        = 4;       // threshold width
    localparam int          SMSC_CAUSE_BUS    = 16;      // bus wake bit
    localparam int          SMSC_CAUSE_DET    = 17;      // detect wake bit
    localparam int          SMSC_RAM_SECT     = 4;       // ram sections
    localparam logic [3:0]  SMSC_RAM_RST      = 4'hf;    // all retained
    localparam logic [31:0] SMSC_CAUSE_RST    = 32'h0;   // cause at reset

    // ------------------------------------------------------------------
    // timing: usb regulator worst case settling
    // ------------------------------------------------------------------
    localparam int SMSC_CLK_MHZ     = 40;                  // clock rate
    localparam int SMSC_USB_SET_US  = 1000;                // settle in us
    localparam int SMSC_USB_SET_CYC = SMSC_USB_SET_US * SMSC_CLK_MHZ;

    // power state
    typedef enum logic [1:0] {
        SMSC_RUN   = 2'b00,   // system running
        SMSC_SLEEP = 2'b01,   // deepest sleep
        SMSC_EMUL  = 2'b10,   // emulated sleep under debug
        SMSC_WAKE  = 2'b11    // wake reset pulse
    } smsc_pwr_t;

endpackage

// File: tb/smsc_top_tb.sv
// Purpose: self-checking bench for the supply monitor and sleep control
// Assumes: 40 MHz clock, plain strobe register port, settle count of 8
// Notes:   async inputs are given several cycles to pass their syncs
`timescale 1ns/1ps

module smsc_top_tb;
    import smsc_pkg::*;

    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    localparam int SET = 8;                 // short settle keeps run brief
    logic        ref_clk_i = 1'b0;          // bench clock
    logic        rst_i, brownout_i, core_pwr_i, high_pwr_i, below_thr_i;
    logic        vbus_i, port_sense_i, high_freq_clock_run_i, debug_mode_i, wr_i, rd_i;
    logic [11:0] addr_i;                    // register address
    logic [31:0] wdata_i, rdata_o, rv;      // bus data and read value
    logic        first_en_o, linear_en_o, switcher_o, pof_on_o, irq_o;
    logic        flash_blk_o, usb_reg_o, sys_rst_o, core_off_o;
    logic [3:0]  pof_thr_o, ram_ret_o;      // threshold and retention
    int          bad_count, num_checks, n;  // tallies and loop index
    // rows: core, high, switcher write, mode, first, linear, switcher
    logic [6:0]  rows [4] = '{7'h62, 7'h71, 7'h2e, 7'h3d};

    always #12.5 ref_clk_i = ~ref_clk_i;    // 25 ns period

    smsc_top #(.USB_SET_CYC(SET)) u_smsc_top (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .brownout_i(brownout_i),
        .core_pwr_i(core_pwr_i), .high_pwr_i(high_pwr_i),
        .below_thr_i(below_thr_i), .vbus_i(vbus_i),
        .port_sense_i(port_sense_i), .high_freq_clock_run_i(high_freq_clock_run_i),
        .debug_mode_i(debug_mode_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .first_en_o(first_en_o), .linear_en_o(linear_en_o),
        .switcher_o(switcher_o), .pof_on_o(pof_on_o), .pof_thr_o(pof_thr_o),
        .flash_blk_o(flash_blk_o), .usb_reg_o(usb_reg_o),
        .sys_rst_o(sys_rst_o), .core_off_o(core_off_o),
        .ram_ret_o(ram_ret_o), .irq_o(irq_o));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // sample a little after the edge so register updates have landed
    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk_i);
        #1;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge ref_clk_i);
        wr_i    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rc(input logic [11:0] a, input logic [31:0] exp);
        @(posedge ref_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge ref_clk_i);
        rd_i   <= 1'b0;
        #1;
        chk(rdata_o, exp);
    endtask

    // wake must come as a bounded reset pulse, then the core runs again
    task automatic wake_seen();
        n = 0;
        while (sys_rst_o !== 1'b1 && n < 12) begin
            tick(1);
            n++;
        end
        chk(sys_rst_o, 1'b1);
        tick(3);
        chk({core_off_o, sys_rst_o}, 2'h0);
    endtask

    task automatic give_verdict();
        if (bad_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // watchdog: the sequence needs well under 2000 cycles
    initial begin
        #100000;
        bad_count++;
        give_verdict();
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        {rst_i, core_pwr_i, high_pwr_i, high_freq_clock_run_i} = 4'hf;
        {brownout_i, below_thr_i, vbus_i, port_sense_i} = 4'h0;
        {debug_mode_i, wr_i, rd_i, addr_i, wdata_i} = '0;
        bad_count = 0;
        num_checks = 0;
        tick(4);
        chk(sys_rst_o, 1'b1);
        repeat (4) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        tick(3);
        chk({linear_en_o, switcher_o, pof_on_o}, 3'h4);
        chk(ram_ret_o, SMSC_RAM_RST);
        chk(rdata_o, 32'h0);
        rc(SMSC_CAUSE_OFS, SMSC_CAUSE_RST);
        rc(SMSC_RAMPWR_OFS, 32'hf);
        wr(12'h004, 32'hffffffff);
        rc(12'h004, 32'h0);
        // supply mode and regulator selection table
        for (n = 0; n < 4; n++) begin
            @(posedge ref_clk_i) core_pwr_i <= rows[n][6];
            high_pwr_i <= rows[n][5];
            wr(SMSC_SWEN_OFS, {31'h0, rows[n][4]});
            tick(4);
            rc(SMSC_MODE_OFS, {31'h0, rows[n][3]});
            chk({first_en_o, linear_en_o, switcher_o}, rows[n][2:0]);
        end
        @(posedge ref_clk_i) core_pwr_i <= 1'b1;
        wr(SMSC_SWEN_OFS, 32'h0);
        // power-fail comparator: off, enable while low, retune, fall
        @(posedge ref_clk_i) below_thr_i <= 1'b1;
        tick(5);
        chk({pof_on_o, flash_blk_o}, 2'h0);
        rc(SMSC_EVT_POWER_FAIL_WARNING_EVENT_OFS, 32'h0);
        wr(SMSC_POFCFG_OFS, 32'h0b);
        tick(4);
        chk({pof_on_o, pof_thr_o}, 5'h15);
        chk(flash_blk_o, 1'b1);
        rc(SMSC_EVT_POWER_FAIL_WARNING_EVENT_OFS, 32'h1);
        wr(SMSC_INTEN_OFS, 32'hf);
        tick(2);
        chk(irq_o, 1'b1);
        wr(SMSC_EVT_POWER_FAIL_WARNING_EVENT_OFS, 32'h0);
        tick(2);
        chk(irq_o, 1'b0);
        wr(SMSC_POFCFG_OFS, 32'h0d);
        tick(3);
        rc(SMSC_EVT_POWER_FAIL_WARNING_EVENT_OFS, 32'h1);
        wr(SMSC_EVT_POWER_FAIL_WARNING_EVENT_OFS, 32'h0);
        @(posedge ref_clk_i) below_thr_i <= 1'b0;
        tick(5);
        chk(flash_blk_o, 1'b0);
        @(posedge ref_clk_i) below_thr_i <= 1'b1;
        tick(5);
        rc(SMSC_EVT_POWER_FAIL_WARNING_EVENT_OFS, 32'h1);
        wr(SMSC_EVT_POWER_FAIL_WARNING_EVENT_OFS, 32'h0);
        @(posedge ref_clk_i) high_freq_clock_run_i <= 1'b0;
        below_thr_i <= 1'b0;
        tick(5);
        @(posedge ref_clk_i) below_thr_i <= 1'b1;
        tick(5);
        chk({pof_on_o, flash_blk_o}, 2'h0);
        rc(SMSC_EVT_POWER_FAIL_WARNING_EVENT_OFS, 32'h0);
        @(posedge ref_clk_i) high_freq_clock_run_i <= 1'b1;
        below_thr_i <= 1'b0;
        wr(SMSC_POFCFG_OFS, 32'h0);
        wr(SMSC_EVT_POWER_FAIL_WARNING_EVENT_OFS, 32'h0);
        // bus voltage detection and usb regulator settling
        wr(SMSC_USBEN_OFS, 32'h1);
        @(posedge ref_clk_i) vbus_i <= 1'b1;
        tick(4);
        chk(usb_reg_o, 1'b1);
        rc(SMSC_USBSTAT_OFS, 32'h1);
        rc(SMSC_EVT_BUSDET_OFS, 32'h1);
        tick(2 * SET);
        rc(SMSC_USBSTAT_OFS, 32'h3);
        rc(SMSC_EVT_USBRDY_OFS, 32'h1);
        @(posedge ref_clk_i) vbus_i <= 1'b0;
        tick(5);
        chk({usb_reg_o, irq_o}, 2'h1);
        rc(SMSC_USBSTAT_OFS, 32'h0);
        rc(SMSC_EVT_BUSREM_OFS, 32'h1);
        // deep sleep, no false wake, wake on bus voltage
        wr(SMSC_RAMPWR_OFS, 32'h5);
        // bench has no transfer in flight when it asks for sleep
        wr(SMSC_SLEEP_OFS, 32'h1);
        tick(2);
        chk({core_off_o, first_en_o, linear_en_o, switcher_o}, 4'h8);
        @(posedge ref_clk_i) below_thr_i <= 1'b1;
        high_freq_clock_run_i <= 1'b0;
        tick(6);
        chk({core_off_o, sys_rst_o, pof_on_o}, 3'h4);
        @(posedge ref_clk_i) below_thr_i <= 1'b0;
        high_freq_clock_run_i <= 1'b1;
        vbus_i <= 1'b1;
        wake_seen();
        chk(ram_ret_o, 4'h5);
        rc(SMSC_CAUSE_OFS, 32'h10000);
        wr(SMSC_CAUSE_OFS, 32'hffffffff);
        rc(SMSC_CAUSE_OFS, 32'h0);
        @(posedge ref_clk_i) vbus_i <= 1'b0;
        // deep sleep, wake on port sense
        wr(SMSC_SLEEP_OFS, 32'h1);
        tick(2);
        chk(core_off_o, 1'b1);
        @(posedge ref_clk_i) port_sense_i <= 1'b1;
        wake_seen();
        @(posedge ref_clk_i) port_sense_i <= 1'b0;
        rc(SMSC_CAUSE_OFS, 32'h20000);
        // debug mode only emulates sleep, power stays up
        @(posedge ref_clk_i) debug_mode_i <= 1'b1;
        wr(SMSC_POFCFG_OFS, 32'h1);
        // bench idles after the command while the core keeps running
        wr(SMSC_SLEEP_OFS, 32'h1);
        tick(3);
        chk({core_off_o, pof_on_o, first_en_o, linear_en_o}, 4'h1);
        rc(SMSC_MODE_OFS, 32'h0);
        // reset leaves emulation, brownout holds system reset
        @(posedge ref_clk_i) rst_i <= 1'b1;
        debug_mode_i <= 1'b0;
        tick(2);
        @(posedge ref_clk_i) rst_i <= 1'b0;
        tick(3);
        chk({core_off_o, pof_on_o, sys_rst_o}, 3'h0);
        @(posedge ref_clk_i) brownout_i <= 1'b1;
        tick(4);
        chk(sys_rst_o, 1'b1);
        @(posedge ref_clk_i) brownout_i <= 1'b0;
        tick(4);
        chk(sys_rst_o, 1'b0);
        give_verdict();
    end

endmodule
